// [core/rscs_regs.vh]
/*
  Constants for the reset strap clock selection block: register offsets,
  field positions, reset values, reference clock table and timing counts.
  Assumes a 20 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
`ifndef RSCS_REGS_VH
`define RSCS_REGS_VH

// Register byte offsets.
`define RSCS_OFF_STRAP_STATUS 8'h00
`define RSCS_OFF_REF_FREQ     8'h04
`define RSCS_OFF_BB_RATE      8'h08
`define RSCS_OFF_AUDIO_CFG    8'h0c
`define RSCS_OFF_AUDIO_RATE   8'h10
`define RSCS_OFF_CONTROL      8'h14
`define RSCS_OFF_PLL_STATUS   8'h18

// Strap status fields.
`define RSCS_ST_CODE_LSB      0
`define RSCS_ST_SOURCE_LSB    4
`define RSCS_ST_CAPTURED_BIT  8
`define RSCS_ST_DRIVEN_BIT    9

// Audio configuration fields.
`define RSCS_AC_SLAVE_BIT     0
`define RSCS_AC_WLEN_LSB      8

// Control fields and reset value.
`define RSCS_CTL_BOOT2_BIT    0
`define RSCS_CTL_STRAP_LSB    1
`define RSCS_CTL_RESET        4'h0

// PLL status fields.
`define RSCS_PS_BYPASS_BIT    0
`define RSCS_PS_STABLE_BIT    1

// Strap codes, ordered [audio bit3, blend, oversample clock].
`define RSCS_CODE_XTAL        3'h0
`define RSCS_CODE_DIG_23M     3'h1
`define RSCS_CODE_DIG_36M     3'h2
`define RSCS_CODE_DIG_2M9     3'h3
`define RSCS_CODE_BB_650      3'h4
`define RSCS_CODE_BB_675      3'h5
`define RSCS_CODE_BB_882      3'h6
`define RSCS_CODE_AUDIO       3'h7

// Reference clock sources.
`define RSCS_SRC_CRYSTAL      2'h0
`define RSCS_SRC_DIGITAL      2'h1
`define RSCS_SRC_BASEBAND     2'h2
`define RSCS_SRC_AUDIO        2'h3

// Reference frequencies in Hz.
`define RSCS_HZ_28M224        32'h01aeaa00
`define RSCS_HZ_23M3472       32'h01644000
`define RSCS_HZ_36M48         32'h022ca400
`define RSCS_HZ_2M9184        32'h002c8800
`define RSCS_HZ_10M4          32'h009eb100
`define RSCS_HZ_10M8          32'h00a4cb80
`define RSCS_HZ_14M112        32'h00d75500

// Baseband sample rates in kS/s and their codes.
`define RSCS_KSPS_650         32'h0000028a
`define RSCS_KSPS_675         32'h000002a3
`define RSCS_KSPS_882         32'h00000372
`define RSCS_BBR_NONE         2'h0
`define RSCS_BBR_650          2'h1
`define RSCS_BBR_675          2'h2
`define RSCS_BBR_882          2'h3

// Audio input settings for the audio bit clock reference.
`define RSCS_AUDIO_RATE_HZ    32'h0000b220
`define RSCS_AUDIO_WLEN       8'h20

// Timing.
`define RSCS_CLK_PERIOD_NS    50
`define RSCS_CFG_HOLD_NS      10
`define RSCS_CFG_HOLD_CYC     (((`RSCS_CFG_HOLD_NS) + (`RSCS_CLK_PERIOD_NS) - 1) / (`RSCS_CLK_PERIOD_NS))

// Bus responses.
`define RSCS_RESP_OKAY        2'h0
`define RSCS_RESP_SLVERR      2'h2

`endif

// [core/rscs_sync.v]
/*
  Two-stage synchroniser for levels entering the system clock domain.
  Assumes the inputs are quasi-static compared with the clock.
*/
`timescale 1ns/100ps

module rscs_sync #(
  parameter WIDTH = 1
) (
  // Clock
  input  wire             aclk,
  // Asynchronous level in, synchronised level out
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage1;

  // The first stage feeds only the second stage.
  always @(posedge aclk) begin
    stage1   <= async_in;
    sync_out <= stage1;
  end

endmodule // rscs_sync

// [core/rscs_top.v]
/*
  Reset strap clock selection: captures the three clock strap pins when
  reset is released, decodes the reference clock mode, holds the PLLs in
  bypass, then turns the strap pins into outputs. Registers on AXI4-Lite.
  Assumes straps are stable around the release of aresetn and that the
  board pulls each undriven strap line up or down to its strap level.
*/
// Our own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/100ps
`include "rscs_regs.vh"

module rscs_top (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write address
  input  wire [7:0]  awaddr,
  input  wire [2:0]  awprot,
  input  wire        awvalid,
  output wire        awready,
  // AXI4-Lite write data
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output wire        wready,
  // AXI4-Lite write response
  output reg  [1:0]  bresp,
  output reg         bvalid,
  input  wire        bready,
  // AXI4-Lite read address
  input  wire [7:0]  araddr,
  input  wire [2:0]  arprot,
  input  wire        arvalid,
  output wire        arready,
  // AXI4-Lite read data
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  output reg         rvalid,
  input  wire        rready,
  // Strap pins
  input  wire        audio_out_bit3_strap_in,
  output reg         audio_out_bit3_strap_out,
  output reg         audio_out_bit3_strap_oe,
  input  wire        blend_strap_in,
  output reg         blend_strap_out,
  output reg         blend_strap_oe,
  input  wire        oversample_clock_strap_in,
  output reg         oversample_clock_strap_out,
  output reg         oversample_clock_strap_oe,
  // Reference clock status
  input  wire        ref_clock_stable,
  // Clock configuration
  output reg         config_valid,
  output reg  [1:0]  ref_source,
  output reg         xtal_enable,
  output reg         pll_bypass,
  output reg  [1:0]  bbi_rate_code,
  output reg         audio_in_slave
);

  reg  [2:0]  strap_code;
  reg         captured;
  reg         strap_driven;
  reg  [1:0]  hold_cnt;
  reg  [3:0]  control;
  reg         aw_held;
  reg         w_held;
  reg  [7:0]  awaddr_q;
  reg  [31:0] wdata_q;
  reg  [3:0]  wstrb_q;
  reg  [31:0] next_rdata;
  reg  [1:0]  next_rresp;
  wire [2:0]  strap_sync;
  wire        stable_sync;
  wire        wr_go;

  // Pins pass two flip-flops before any logic reads them.
  rscs_sync #(
    .WIDTH (3)
  ) u_strap_sync (
    .aclk     (aclk),
    .async_in ({audio_out_bit3_strap_in, blend_strap_in,
                oversample_clock_strap_in}),
    .sync_out (strap_sync)
  );

  rscs_sync #(
    .WIDTH (1)
  ) u_stable_sync (
    .aclk     (aclk),
    .async_in (ref_clock_stable),
    .sync_out (stable_sync)
  );

  // Reference source for a strap code.
  function [1:0] code_source;
    input [2:0] code;
    begin
      if (code == `RSCS_CODE_XTAL) begin
        code_source = `RSCS_SRC_CRYSTAL;
      end else if (code == `RSCS_CODE_AUDIO) begin
        code_source = `RSCS_SRC_AUDIO;
      end else if (code[2]) begin
        code_source = `RSCS_SRC_BASEBAND;
      end else begin
        code_source = `RSCS_SRC_DIGITAL;
      end
    end
  endfunction

  // Reference frequency in Hz for a strap code.
  function [31:0] code_freq;
    input [2:0] code;
    begin
      case (code)
        `RSCS_CODE_XTAL:    code_freq = `RSCS_HZ_28M224;
        `RSCS_CODE_DIG_23M: code_freq = `RSCS_HZ_23M3472;
        `RSCS_CODE_DIG_36M: code_freq = `RSCS_HZ_36M48;
        `RSCS_CODE_DIG_2M9: code_freq = `RSCS_HZ_2M9184;
        `RSCS_CODE_BB_650:  code_freq = `RSCS_HZ_10M4;
        `RSCS_CODE_BB_675:  code_freq = `RSCS_HZ_10M8;
        `RSCS_CODE_BB_882:  code_freq = `RSCS_HZ_14M112;
        default:            code_freq = `RSCS_HZ_2M9184;
      endcase
    end
  endfunction

  // Baseband rate code required of the tuner for a strap code.
  function [1:0] code_bbr;
    input [2:0] code;
    begin
      case (code)
        `RSCS_CODE_BB_650: code_bbr = `RSCS_BBR_650;
        `RSCS_CODE_BB_675: code_bbr = `RSCS_BBR_675;
        `RSCS_CODE_BB_882: code_bbr = `RSCS_BBR_882;
        default:           code_bbr = `RSCS_BBR_NONE;
      endcase
    end
  endfunction

  // Register address decode for writes; reads decode the address in the read data selection.
  function mapped;
    input [7:0] addr;
    begin
      if (addr == `RSCS_OFF_STRAP_STATUS) begin
        mapped = 1'b1;
      end else if (addr == `RSCS_OFF_REF_FREQ) begin
        mapped = 1'b1;
      end else if (addr == `RSCS_OFF_BB_RATE) begin
        mapped = 1'b1;
      end else if (addr == `RSCS_OFF_AUDIO_CFG) begin
        mapped = 1'b1;
      end else if (addr == `RSCS_OFF_AUDIO_RATE) begin
        mapped = 1'b1;
      end else if (addr == `RSCS_OFF_CONTROL) begin
        mapped = 1'b1;
      end else if (addr == `RSCS_OFF_PLL_STATUS) begin
        mapped = 1'b1;
      end else begin
        mapped = 1'b0;
      end
    end
  endfunction

  // The synchronised straps still show the pre-release levels on the
  // first edge after release, so that edge is the capture point.
  always @(posedge aclk) begin
    if (!aresetn) begin
      strap_code <= 3'h0;
      captured   <= 1'b0;
    end else if (!captured) begin
      strap_code <= strap_sync;
      captured   <= 1'b1;
    end
  end

  // Straps turn into outputs once the configuration hold time has passed.
  always @(posedge aclk) begin
    if (!aresetn) begin
      hold_cnt     <= 2'h0;
      strap_driven <= 1'b0;
    end else if (captured && !strap_driven) begin
      if ({30'h0, hold_cnt} >= `RSCS_CFG_HOLD_CYC - 1) begin
        strap_driven <= 1'b1;
      end else begin
        hold_cnt <= hold_cnt + 2'h1;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      audio_out_bit3_strap_oe    <= 1'b0;
      blend_strap_oe             <= 1'b0;
      oversample_clock_strap_oe  <= 1'b0;
      audio_out_bit3_strap_out   <= 1'b0;
      blend_strap_out            <= 1'b0;
      oversample_clock_strap_out <= 1'b0;
    end else begin
      audio_out_bit3_strap_oe    <= strap_driven;
      blend_strap_oe             <= strap_driven;
      oversample_clock_strap_oe  <= strap_driven;
      audio_out_bit3_strap_out   <= control[`RSCS_CTL_STRAP_LSB + 2];
      blend_strap_out            <= control[`RSCS_CTL_STRAP_LSB + 1];
      oversample_clock_strap_out <= control[`RSCS_CTL_STRAP_LSB];
    end
  end

  // Decoded clock configuration, valid once the code is captured.
  always @(posedge aclk) begin
    if (!aresetn) begin
      config_valid   <= 1'b0;
      ref_source     <= `RSCS_SRC_CRYSTAL;
      xtal_enable    <= 1'b0;
      bbi_rate_code  <= `RSCS_BBR_NONE;
      audio_in_slave <= 1'b0;
      pll_bypass     <= 1'b1;
    end else begin
      config_valid   <= captured;
      ref_source     <= code_source(strap_code);
      xtal_enable    <= captured && (strap_code == `RSCS_CODE_XTAL);
      bbi_rate_code  <= code_bbr(strap_code);
      audio_in_slave <= strap_code == `RSCS_CODE_AUDIO;
      pll_bypass     <= !(captured && stable_sync &&
                          control[`RSCS_CTL_BOOT2_BIT]);
    end
  end

  // Write channel: address and data are taken in either order.
  assign awready = !aw_held && !bvalid;
  assign wready  = !w_held && !bvalid;
  assign wr_go   = aw_held && w_held && !bvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held  <= 1'b0;
      w_held   <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q  <= 32'h00000000;
      wstrb_q  <= 4'h0;
      bvalid   <= 1'b0;
      bresp    <= `RSCS_RESP_OKAY;
      control  <= `RSCS_CTL_RESET;
    end else begin
      if (awvalid && awready) begin
        aw_held  <= 1'b1;
        awaddr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_held  <= 1'b1;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        bvalid  <= 1'b1;
        if (!mapped(awaddr_q)) begin
          bresp <= `RSCS_RESP_SLVERR;
        end else begin
          bresp <= `RSCS_RESP_OKAY;
        end
        if (awaddr_q == `RSCS_OFF_CONTROL && wstrb_q[0]) begin
          control <= wdata_q[3:0];
        end
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Read data selection.
  always @* begin
    next_rdata = 32'h00000000;
    next_rresp = `RSCS_RESP_OKAY;
    if (araddr == `RSCS_OFF_STRAP_STATUS) begin
      next_rdata[`RSCS_ST_CODE_LSB +: 3]    = strap_code;
      next_rdata[`RSCS_ST_SOURCE_LSB +: 2]  = code_source(strap_code);
      next_rdata[`RSCS_ST_CAPTURED_BIT]     = captured;
      next_rdata[`RSCS_ST_DRIVEN_BIT]       = strap_driven;
    end else if (araddr == `RSCS_OFF_REF_FREQ) begin
      next_rdata = code_freq(strap_code);
    end else if (araddr == `RSCS_OFF_BB_RATE) begin
      case (code_bbr(strap_code))
        `RSCS_BBR_650: next_rdata = `RSCS_KSPS_650;
        `RSCS_BBR_675: next_rdata = `RSCS_KSPS_675;
        `RSCS_BBR_882: next_rdata = `RSCS_KSPS_882;
        default:       next_rdata = 32'h00000000;
      endcase
    end else if (araddr == `RSCS_OFF_AUDIO_CFG) begin
      if (strap_code == `RSCS_CODE_AUDIO) begin
        next_rdata[`RSCS_AC_SLAVE_BIT]    = 1'b1;
        next_rdata[`RSCS_AC_WLEN_LSB +: 8] = `RSCS_AUDIO_WLEN;
      end
    end else if (araddr == `RSCS_OFF_AUDIO_RATE) begin
      if (strap_code == `RSCS_CODE_AUDIO) begin
        next_rdata = `RSCS_AUDIO_RATE_HZ;
      end
    end else if (araddr == `RSCS_OFF_CONTROL) begin
      next_rdata[3:0] = control;
    end else if (araddr == `RSCS_OFF_PLL_STATUS) begin
      next_rdata[`RSCS_PS_BYPASS_BIT] = pll_bypass;
      next_rdata[`RSCS_PS_STABLE_BIT] = stable_sync;
    end else begin
      next_rresp = `RSCS_RESP_SLVERR;
    end
  end

  // Read channel: one read outstanding, answered the cycle after.
  assign arready = !rvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h00000000;
      rresp  <= `RSCS_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= next_rdata;
      rresp  <= next_rresp;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule // rscs_top

// [tb/rscs_board.sv]
/*
  Board model: strap resistors and the external reference clock source.
  Assumes the bench picks the fitted pull-ups and starts the clock.
*/
`timescale 1ns/100ps

module rscs_board (
  // Clock
  input  logic       aclk,
  // Board set-up
  input  logic [2:0] pull_up,
  input  logic       clk_on,
  input  logic [7:0] start_dly,
  // Strap lines
  input  logic [2:0] dev_out,
  input  logic [2:0] dev_oe,
  output logic [2:0] pin,
  // Reference clock state
  output logic       ref_clock_stable = 1'b0
);
  logic [7:0] cnt = 8'h00;

  // A driven line follows the device, an open one its resistor.
  assign pin = (dev_oe & dev_out) | (~dev_oe & pull_up);

  // The source settles a chosen number of cycles after it starts.
  always @(posedge aclk) begin
    cnt <= !clk_on ? 8'h00 : (cnt == start_dly ? cnt : cnt + 8'h01);
    ref_clock_stable <= clk_on && (cnt == start_dly);
  end
endmodule // rscs_board

// [tb/rscs_checker.sv]
/*
  Checker for the strap clock selection block, bound to its top module.
  Assumes one clock, aclk, and a synchronous active-low aresetn.
*/
`timescale 1ns/100ps
`include "rscs_regs.vh"

module rscs_checker (
  // Clock and reset
  input logic       aclk,
  input logic       aresetn,
  // Strap drive
  input logic       audio_out_bit3_strap_oe,
  input logic       blend_strap_oe,
  input logic       oversample_clock_strap_oe,
  // Clock configuration
  input logic       ref_clock_stable,
  input logic       config_valid,
  input logic [1:0] ref_source,
  input logic       xtal_enable,
  input logic       pll_bypass,
  input logic [1:0] bbi_rate_code,
  input logic       audio_in_slave
);
  logic [2:0] rel;
  wire  [2:0] oe;

  assign oe = {audio_out_bit3_strap_oe, blend_strap_oe,
               oversample_clock_strap_oe};

  // Counts edges since reset release.
  always @(posedge aclk) begin
    if (!aresetn) rel <= 3'h0;
    else if (rel != 3'h7) rel <= rel + 3'h1;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_oe_early: assert property (rel < 3'h3 |-> oe == 3'h0)
    else $error("strap lines driven too early");
  a_oe_on: assert property (rel >= 3'h3 |-> oe == 3'h7)
    else $error("strap lines not driven");
  a_cfg_time: assert property (config_valid == (rel >= 3'h2))
    else $error("configuration valid at wrong time");
  a_code_held: assert property (rel >= 3'h3 |-> $stable(ref_source)
    && $stable(bbi_rate_code) && $stable(xtal_enable))
    else $error("captured configuration changed");
  a_xtal_src: assert property (config_valid |->
    xtal_enable == (ref_source == `RSCS_SRC_CRYSTAL))
    else $error("crystal enable disagrees with source");
  a_bb_rate: assert property (config_valid |->
    (bbi_rate_code != 2'h0) == (ref_source == `RSCS_SRC_BASEBAND))
    else $error("baseband rate disagrees with source");
  a_audio_src: assert property (audio_in_slave ==
    (config_valid && ref_source == `RSCS_SRC_AUDIO))
    else $error("audio slave disagrees with source");
  a_pll_fall: assert property ($fell(pll_bypass) |->
    $past(ref_clock_stable, 3) && config_valid)
    else $error("bypass left without stable clock");
  a_pll_back: assert property (!ref_clock_stable |-> ##3 pll_bypass)
    else $error("bypass not restored");
endmodule // rscs_checker

bind rscs_top rscs_checker rscs_checker_inst (
  .aclk(aclk), .aresetn(aresetn),
  .audio_out_bit3_strap_oe(audio_out_bit3_strap_oe),
  .blend_strap_oe(blend_strap_oe),
  .oversample_clock_strap_oe(oversample_clock_strap_oe),
  .ref_clock_stable(ref_clock_stable), .config_valid(config_valid),
  .ref_source(ref_source), .xtal_enable(xtal_enable),
  .pll_bypass(pll_bypass), .bbi_rate_code(bbi_rate_code),
  .audio_in_slave(audio_in_slave)
);

// [tb/tb_top.sv]
/*
  Bench: runs every strap code through reset, reads the registers and
  checks pins and clock outputs. Assumes the board model and the checker.
*/
`timescale 1ns/100ps
`include "rscs_regs.vh"

module tb_top;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, clk_on;
  logic        ref_clock_stable, config_valid, xtal_enable, pll_bypass;
  logic        audio_in_slave;
  logic [1:0]  bresp, rresp, ref_source, bbi_rate_code, src, bbc;
  logic [2:0]  awprot, arprot, pull_up, pin, s_out, s_oe;
  logic [3:0]  wstrb;
  logic [7:0]  awaddr, araddr, dly;
  logic [31:0] wdata, rdata, rng;
  logic [33:0] exp_rd[$];
  logic [1:0]  exp_wr[$];
  int          failures, n_tests;
  logic [31:0] freq[8] = '{`RSCS_HZ_28M224, `RSCS_HZ_23M3472, `RSCS_HZ_36M48,
    `RSCS_HZ_2M9184, `RSCS_HZ_10M4, `RSCS_HZ_10M8, `RSCS_HZ_14M112,
    `RSCS_HZ_2M9184};
  logic [31:0] ksr[4] = '{32'h0, `RSCS_KSPS_650, `RSCS_KSPS_675,
    `RSCS_KSPS_882};

  rscs_top rscs_top_inst (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(awprot),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arprot(arprot), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .audio_out_bit3_strap_in(pin[2]),
    .audio_out_bit3_strap_out(s_out[2]), .audio_out_bit3_strap_oe(s_oe[2]),
    .blend_strap_in(pin[1]), .blend_strap_out(s_out[1]),
    .blend_strap_oe(s_oe[1]), .oversample_clock_strap_in(pin[0]),
    .oversample_clock_strap_out(s_out[0]),
    .oversample_clock_strap_oe(s_oe[0]),
    .ref_clock_stable(ref_clock_stable), .config_valid(config_valid),
    .ref_source(ref_source), .xtal_enable(xtal_enable),
    .pll_bypass(pll_bypass), .bbi_rate_code(bbi_rate_code),
    .audio_in_slave(audio_in_slave));

  rscs_board rscs_board_inst (
    .aclk(aclk), .pull_up(pull_up), .clk_on(clk_on), .start_dly(dly),
    .dev_out(s_out), .dev_oe(s_oe), .pin(pin),
    .ref_clock_stable(ref_clock_stable));

  always #25 aclk = ~aclk;

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_rd(input logic [33:0] got, input logic [33:0] exp);
    chk(got, exp);
  endtask

  task automatic chk_wr(input logic [1:0] got, input logic [1:0] exp);
    chk({32'h0, got}, {32'h0, exp});
  endtask

  task automatic chk_cfg(input logic [33:0] got, input logic [33:0] exp);
    chk(got, exp);
  endtask

  task automatic wrap_up;
    $display("compares %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    @(posedge aclk);
    exp_wr.push_back(r);
    awaddr <= a;
    awprot <= rng[2:0];
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    @(posedge aclk);
    exp_rd.push_back(e);
    araddr <= a;
    arprot <= rng[5:3];
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
  endtask

  // Takes the oldest noted result as each response is accepted.
  always @(posedge aclk) begin
    if (rvalid && rready) chk_rd({rresp, rdata}, exp_rd.pop_front());
    if (bvalid && bready) chk_wr(bresp, exp_wr.pop_front());
  end

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, clk_on} = 6'h00;
    {awaddr, araddr, wdata, awprot, arprot} = 54'h0;
    {wstrb, pull_up, dly, rng} = {4'hf, 3'h0, 8'h05, 32'h04b83182};
    repeat (8) @(posedge aclk);
    clk_on <= 1'b1;
    wait (ref_clock_stable);
    repeat (40000) @(posedge aclk);
    for (int c = 0; c < 8; c++) begin
      @(posedge aclk);
      aresetn <= 1'b0;
      pull_up <= c[2:0];
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      src = c == 0 ? 2'h0 : c < 4 ? 2'h1 : c < 7 ? 2'h2 : 2'h3;
      bbc = src == 2'h2 ? c[1:0] + 2'h1 : 2'h0;
      repeat (4) @(posedge aclk);
      chk_cfg({config_valid, ref_source, xtal_enable, bbi_rate_code,
        audio_in_slave, pll_bypass, s_oe}, {1'b1, src, c == 0, bbc, c == 7,
        1'b1, 3'h7});
      rd(`RSCS_OFF_CONTROL, 34'h0);
      rd(`RSCS_OFF_REF_FREQ, {2'h0, freq[c]});
      rd(`RSCS_OFF_BB_RATE, {2'h0, ksr[bbc]});
      rd(`RSCS_OFF_AUDIO_CFG, c == 7 ? 34'h2001 : 34'h0);
      rd(`RSCS_OFF_AUDIO_RATE, c == 7 ? 34'hb220 : 34'h0);
      rng = xs(rng);
      wr(`RSCS_OFF_CONTROL, {rng[31:4], ~c[2:0], 1'b1}, 2'h0);
      rd(`RSCS_OFF_CONTROL, {30'h0, ~c[2:0], 1'b1});
      rd(`RSCS_OFF_STRAP_STATUS, {28'hc, src, 1'b0, c[2:0]});
      rd(`RSCS_OFF_PLL_STATUS, 34'h2);
      chk_cfg({s_oe, pin, pll_bypass}, {3'h7, ~c[2:0], 1'b0});
      $display("code %0d done", c);
    end
    clk_on <= 1'b0;
    repeat (5) @(posedge aclk);
    rd(`RSCS_OFF_PLL_STATUS, 34'h1);
    rng = xs(rng);
    dly <= rng[7:0];
    clk_on <= 1'b1;
    repeat (270) @(posedge aclk);
    rd(`RSCS_OFF_PLL_STATUS, 34'h2);
    rd(8'h1c, {`RSCS_RESP_SLVERR, 32'h0});
    wr(8'h20, rng, `RSCS_RESP_SLVERR);
    wr(`RSCS_OFF_REF_FREQ, rng, 2'h0);
    rd(`RSCS_OFF_REF_FREQ, {2'h0, `RSCS_HZ_2M9184});
    wstrb <= 4'he;
    wr(`RSCS_OFF_CONTROL, 32'h0, 2'h0);
    rd(`RSCS_OFF_CONTROL, 34'h1);
    rd(`RSCS_OFF_PLL_STATUS, 34'h2);
    $display("bus and clock checks done");
    wrap_up();
  end

  // About 40650 cycles are expected; the limit leaves ample margin.
  initial begin
    #(60000 * 50);
    failures++;
    wrap_up();
  end
endmodule // tb_top
